//--- remap_pkg.sv
// Package: constants, register map and bus carriers of the pin remap fabric
package remap_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and counts
   localparam int DW          = 16;   // Register width
   localparam int BUS_DW      = 32;   // Bus data width
   localparam int ADR_W       = 10;   // Byte address width
   localparam int IDX_W       = 8;    // Word index width
   localparam int SRC_W       = 8;    // Input source field width
   localparam int SEL_W       = 6;    // Output selector field width
   localparam int NUM_SRC     = 256;  // Pin numbers an input field can name
   localparam int NUM_CODES   = 64;   // Output selector codes
   localparam int NUM_IN_REG  = 24;   // Input source registers
   localparam int NUM_FUNC    = 48;   // Two field slots per input register
   localparam int NUM_OUT_REG = 23;   // Output select registers
   localparam int NUM_OUT_PIN = 46;   // Two pins per output register
   localparam int NUM_PHYS    = 40;   // Pins with a pad
   localparam int NUM_VIRT    = 6;    // Pins without a pad

   ////////////////////////////////////////////////////////////////////////
   // Pin numbering
   localparam int PHYS_PIN_FIRST = 32;   // Pin number of output slot 0
   localparam int VIRT_PIN_FIRST = 170;  // Pin number of first virtual pin
   localparam int VIRT_REG_FIRST = 20;   // First of the output registers 20..22 holding virtual pins

   ////////////////////////////////////////////////////////////////////////
   // Register map, word indices (byte address = index * 4)
   localparam logic [IDX_W-1:0] IDX_LOCK     = 8'h00;
   localparam logic [IDX_W-1:0] IDX_IN_BASE  = 8'h01;
   localparam logic [IDX_W-1:0] IDX_OUT_BASE = 8'h20;
   localparam logic [IDX_W-1:0] IDX_IN_CNT   = 8'h18;
   localparam logic [IDX_W-1:0] IDX_OUT_CNT  = 8'h17;

   ////////////////////////////////////////////////////////////////////////
   // Field layout and reset values
   localparam int LOCK_BIT   = 11;  // Mapping lock bit position
   localparam int LO_LSB     = 0;   // Lower field of a register
   localparam int HI_LSB     = 8;   // Upper field of a register
   localparam logic [DW-1:0] OUT_MASK  = 16'h3F3F;  // Two selectors
   localparam logic [DW-1:0] IN_RESET  = 16'h0000;
   localparam logic [DW-1:0] OUT_RESET = 16'h0000;
   // Which input registers implement their lower / upper field
   localparam logic [NUM_IN_REG-1:0] IN_LO_MASK = 24'hDE7FFA;
   localparam logic [NUM_IN_REG-1:0] IN_HI_MASK = 24'hEDFFFF;

   ////////////////////////////////////////////////////////////////////////
   // Output selector codes
   localparam logic [SEL_W-1:0] CODE_NULL    = 6'h00;  // Default port
   localparam logic [SEL_W-1:0] CODE_UART_TX = 6'h01;  // First UART TX

   ////////////////////////////////////////////////////////////////////////
   // Wishbone carriers
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADR_W-1:0]  adr;
      logic [3:0]        sel;
      logic [BUS_DW-1:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic              ack;
      logic [BUS_DW-1:0] dat;
   } wb_rsp_t;

endpackage

//--- out_pin_sel.sv
// One output pin: selector code picks the peripheral output driving it
`timescale 1ns/1ps
module out_pin_sel
(
   // Clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            srst_i,
   // Selector and peripheral outputs
   input  wire logic [remap_pkg::SEL_W-1:0]     sel_i,
   input  wire logic [remap_pkg::NUM_CODES-1:0] periph_i,
   // Pin side
   output logic                                 pin_o,
   output logic                                 own_o
);
   import remap_pkg::*;

   logic is_null;
   logic pin_nxt;

   // Null code keeps the pin on its port function and drives nothing
   assign is_null = (sel_i == CODE_NULL);           // see R4
   assign pin_nxt = is_null ? 1'b0 : periph_i[sel_i]; // see R3 see R8

   // Registered so every pad sees a clean flop output
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pin_o <= 1'b0;
         own_o <= 1'b0;
      end
      else
      begin
         pin_o <= pin_nxt;
         own_o <= ~is_null;
      end
   end

endmodule

//--- pin_remap_fabric.sv
// Pin remap fabric: input sources per function, output selectors per pin
//
// Operation
// R1 - Outputs are chosen per pin, each pin owning its own selector.
// R2 - Each output register holds 6-bit selector fields, one per pin.
// R3 - A selector value picks one peripheral whose output drives the pin.
// R4 - Selectors reset to zero; zero is the null connection.
// R5 - Six virtual pins 170 to 175 behave as pins without a pad.
// R6 - Virtual pin selectors live in output registers 20, 21 and 22.
// R7 - Each input function has an 8-bit field naming its source pin.
// R8 - Code 000001 drives first UART transmit; 000000 keeps port function.
// R9 - No lockout between fields; many-to-one and one-to-many accepted.
// R10 - While lock bit set, mapping writes are ignored; clearing re-enables.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module pin_remap_fabric
(
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              srst_i,
   // Wishbone slave
   input  wire remap_pkg::wb_req_t                wb_i,
   output remap_pkg::wb_rsp_t                     wb_o,
   // Pad levels seen by the input side, indexed by pin number
   input  wire logic [remap_pkg::NUM_SRC-1:0]     pin_level_i,
   // Peripheral outputs, indexed by selector code
   input  wire logic [remap_pkg::NUM_CODES-1:0]   periph_out_i,
   // Peripheral inputs, two slots per input register
   output logic      [remap_pkg::NUM_FUNC-1:0]    func_in_o,
   // Physical output pins
   output logic      [remap_pkg::NUM_PHYS-1:0]    pin_out_o,
   output logic      [remap_pkg::NUM_PHYS-1:0]    pin_own_o,
   // Virtual pins
   output logic      [remap_pkg::NUM_VIRT-1:0]    virt_out_o,
   // Lock state
   output logic                                   lock_o
);
   import remap_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [DW-1:0]        in_reg_r  [NUM_IN_REG];
   logic [DW-1:0]        out_reg_r [NUM_OUT_REG];
   logic                 lock_r;
   logic                 ack_r;
   logic [BUS_DW-1:0]    rdat_r;
   logic [NUM_FUNC-1:0]  func_r;
   logic [NUM_OUT_PIN-1:0] sel_pin;
   logic [NUM_OUT_PIN-1:0] sel_own;
   logic [NUM_SRC-1:0]   src_bus;

   logic                 access;
   logic                 wr_en;
   logic [IDX_W-1:0]     idx;
   logic [IDX_W-1:0]     in_off;
   logic [IDX_W-1:0]     out_off;
   logic                 hit_lock;
   logic                 hit_in;
   logic                 hit_out;
   logic                 map_wr_ok;
   logic [DW-1:0]        wmask;
   logic [DW-1:0]        wdat;
   logic [DW-1:0]        rd_word;
   logic [DW-1:0]        rd_in;
   logic [DW-1:0]        rd_out;
   logic                 lock_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   // A request is taken once; the ack flop blocks a second take of the
   // same request while the master is still holding it.
   assign access   = wb_i.cyc & wb_i.stb & ~ack_r;
   assign wr_en    = access & wb_i.we;
   assign idx      = wb_i.adr[ADR_W-1:2];
   assign in_off   = idx - IDX_IN_BASE;
   assign out_off  = idx - IDX_OUT_BASE;
   assign hit_lock = (idx == IDX_LOCK);
   assign hit_in   = (idx >= IDX_IN_BASE) &&
                     (idx <  IDX_IN_BASE + IDX_IN_CNT);
   assign hit_out  = (idx >= IDX_OUT_BASE) &&
                     (idx <  IDX_OUT_BASE + IDX_OUT_CNT);

   // Byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 dropped
   assign wmask = {{8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
   assign wdat  = wb_i.dat[DW-1:0];

   // Mapping registers accept writes only while unlocked
   assign map_wr_ok = wr_en & ~lock_r;                  // see R10

   // Lock bit sits in lane 1; it stays writable so it can be cleared
   assign lock_nxt = (wr_en & hit_lock & wb_i.sel[1]) ?
                     wdat[LOCK_BIT] : lock_r;           // see R10

   ////////////////////////////////////////////////////////////////////////
   // Read data selection
   assign rd_in  = hit_in  ? in_reg_r[in_off[4:0]]   : '0;
   assign rd_out = hit_out ? out_reg_r[out_off[4:0]] : '0;

   // Unmapped words read as zero and still get an ack
   always_comb
   begin
      rd_word = '0;
      if (hit_lock)
      begin
         rd_word[LOCK_BIT] = lock_r;
      end
      else if (hit_in)
      begin
         rd_word = rd_in;
      end
      else if (hit_out)
      begin
         rd_word = rd_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait-free cycle, ack high for exactly one cycle
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         ack_r  <= 1'b0;
         rdat_r <= '0;
      end
      else
      begin
         ack_r  <= access;
         rdat_r <= {{(BUS_DW-DW){1'b0}}, rd_word};
      end
   end

   assign wb_o.ack = ack_r;
   assign wb_o.dat = rdat_r;

   ////////////////////////////////////////////////////////////////////////
   // Lock register
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         lock_r <= 1'b0;
      end
      else
      begin
         lock_r <= lock_nxt;
      end
   end

   assign lock_o = lock_r;

   ////////////////////////////////////////////////////////////////////////
   // Input source registers, one per generate entry.
   // Unimplemented halves are masked so they read back as zero.
   for (genvar r = 0; r < NUM_IN_REG; r++)
   begin : g_in_reg
      logic [DW-1:0] fmask;
      logic          hit_me;
      logic [DW-1:0] keep;

      assign fmask  = {{8{IN_HI_MASK[r]}}, {8{IN_LO_MASK[r]}}};
      assign hit_me = hit_in && (in_off == IDX_W'(r));
      assign keep   = in_reg_r[r] & ~wmask;

      // Field holds the pin number feeding the function, see R7
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            in_reg_r[r] <= IN_RESET;
         end
         else if (map_wr_ok && hit_me)                  // see R10
         begin
            in_reg_r[r] <= keep | (wdat & wmask & fmask);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output select registers; each 16-bit word holds two 6-bit selectors
   for (genvar r = 0; r < NUM_OUT_REG; r++)
   begin : g_out_reg
      logic          hit_me;
      logic [DW-1:0] keep;

      assign hit_me = hit_out && (out_off == IDX_W'(r));
      assign keep   = out_reg_r[r] & ~wmask;

      // Reset to the null code so no peripheral reaches a pad, see R4
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            out_reg_r[r] <= OUT_RESET;                  // see R4
         end
         else if (map_wr_ok && hit_me)                  // see R10
         begin
            out_reg_r[r] <= keep | (wdat & wmask & OUT_MASK); // see R2
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output selection, one selector per pin rather than per peripheral.
   // Even slot uses the lower field, odd slot the upper field.
   // Slots 40..45 are registers 20..22, the virtual pins, see R6
   for (genvar p = 0; p < NUM_OUT_PIN; p++)
   begin : g_out_pin
      logic [SEL_W-1:0] sel;

      if (p % 2 == 0)
      begin : g_lo
         assign sel = out_reg_r[p/2][LO_LSB +: SEL_W];  // see R2
      end
      else
      begin : g_hi
         assign sel = out_reg_r[p/2][HI_LSB +: SEL_W];  // see R2
      end

      // Several pins may pick the same code; nothing arbitrates, see R9
      out_pin_sel u_sel
      (
         .clk_i    (clk_i),
         .srst_i   (srst_i),
         .sel_i    (sel),
         .periph_i (periph_out_i),
         .pin_o    (sel_pin[p]),
         .own_o    (sel_own[p])
      );                                                // see R1 see R3
   end

   assign pin_out_o  = sel_pin[NUM_PHYS-1:0];
   assign pin_own_o  = sel_own[NUM_PHYS-1:0];
   assign virt_out_o = sel_pin[NUM_OUT_PIN-1:NUM_PHYS]; // see R5

   ////////////////////////////////////////////////////////////////////////
   // Source bus for the input side.
   // Virtual pins have no pad: their number carries the virtual output
   // back in, so one peripheral can feed another without a pin.
   for (genvar b = 0; b < NUM_SRC; b++)
   begin : g_src
      if (b >= VIRT_PIN_FIRST && b < VIRT_PIN_FIRST + NUM_VIRT)
      begin : g_virt
         assign src_bus[b] = sel_pin[NUM_PHYS + b - VIRT_PIN_FIRST]; // see R5
      end
      else
      begin : g_pad
         assign src_bus[b] = pin_level_i[b];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input selection, one source field per function.
   // Any number of functions may name the same pin, see R9
   for (genvar f = 0; f < NUM_FUNC; f++)
   begin : g_func
      logic [SRC_W-1:0] src;
      logic             present;

      if (f % 2 == 0)
      begin : g_lo
         assign src     = in_reg_r[f/2][LO_LSB +: SRC_W]; // see R7
         assign present = IN_LO_MASK[f/2];
      end
      else
      begin : g_hi
         assign src     = in_reg_r[f/2][HI_LSB +: SRC_W]; // see R7
         assign present = IN_HI_MASK[f/2];
      end

      // Absent slots stay low so an unused function never toggles
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            func_r[f] <= 1'b0;
         end
         else
         begin
            func_r[f] <= present & src_bus[src];        // see R7
         end
      end
   end

   assign func_in_o = func_r;

endmodule

//--- pin_remap_fabric_props.sv
// Checker: bus handshake, reset state and selector effects of the fabric
`timescale 1ns/1ps
module pin_remap_fabric_props
(
   // Clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           srst_i,
   // Register bus
   input  wire remap_pkg::wb_req_t             wb_i,
   input  wire remap_pkg::wb_rsp_t             wb_o,
   // Pin side
   input  wire logic [remap_pkg::NUM_PHYS-1:0] pin_own_o,
   input  wire logic [remap_pkg::NUM_VIRT-1:0] virt_out_o,
   input  wire logic                           lock_o
);
   import remap_pkg::*;
   ////////////////////////////////////////
   // Taken requests; a pending ack blocks a new take
   wire take  = wb_i.cyc & wb_i.stb & ~wb_o.ack;
   wire wr_o0 = take & wb_i.we & wb_i.sel[0] & (wb_i.adr[9:2] == IDX_OUT_BASE);
   wire wr_lk = take & wb_i.we & wb_i.sel[1] & (wb_i.adr[9:2] == IDX_LOCK);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////
   property p_ack_one; wb_o.ack |=> !wb_o.ack; endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("ack held longer than one cycle");
   property p_ack_due; take |=> wb_o.ack; endproperty
   a_ack_due: assert property (p_ack_due)
      else $error("taken request not answered next cycle");
   property p_ack_cause; !(wb_i.cyc && wb_i.stb) |=> !wb_o.ack; endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without a request");
   property p_rd_hi; wb_o.ack |-> wb_o.dat[31:16] == 16'h0000; endproperty
   a_rd_hi: assert property (p_rd_hi)
      else $error("upper read lanes not zero");
   property p_rst;
      $fell(srst_i) |-> !pin_own_o && !virt_out_o && !lock_o;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
   property p_sel_on;
      wr_o0 && !lock_o && wb_i.dat[5:0] != 6'h00 |-> ##2 pin_own_o[0];
   endproperty
   a_sel_on: assert property (p_sel_on)
      else $error("nonzero selector did not take the pin");
   property p_sel_off;
      wr_o0 && !lock_o && wb_i.dat[5:0] == 6'h00 |-> ##2 !pin_own_o[0];
   endproperty
   a_sel_off: assert property (p_sel_off)
      else $error("zero selector left the pin owned");
   property p_locked; wr_o0 && lock_o |-> ##2 $stable(pin_own_o[0]); endproperty
   a_locked: assert property (p_locked)
      else $error("locked write changed a pin");
   property p_lock_wr; wr_lk |=> lock_o == $past(wb_i.dat[11]); endproperty
   a_lock_wr: assert property (p_lock_wr)
      else $error("lock bit not written");
endmodule

//--- remap_far_side.sv
// Far side: peripheral outputs and pad levels, fresh every cycle
`timescale 1ns/1ps
module remap_far_side
(
   // Clock
   input  wire logic                       clk_i,
   // Levels toward the fabric
   output logic [remap_pkg::NUM_CODES-1:0] periph_o,
   output logic [remap_pkg::NUM_SRC-1:0]   level_o
);
   import remap_pkg::*;
   // New values each cycle so a stale or wrong pick shows up; one driver
   // per output, the first edge lands while the fabric is still in reset
   always @(posedge clk_i)
   begin
      periph_o <= {$urandom, $urandom};
      for (int i = 0; i < 8; i++)
         level_o[i*32 +: 32] <= $urandom;
   end
endmodule

//--- tb_pin_remap_fabric.sv
// Testbench: register model, pin and function checks of the remap fabric
`timescale 1ns/1ps
module tb_pin_remap_fabric;
   import remap_pkg::*;
   logic                 clk_i = 1'b0;
   logic                 srst_i = 1'b1;
   wb_req_t              req = '0;
   wb_rsp_t              rsp;
   logic [NUM_SRC-1:0]   lvl;
   logic [NUM_CODES-1:0] per;
   logic [NUM_FUNC-1:0]  fin;
   logic [NUM_PHYS-1:0]  pout;
   logic [NUM_PHYS-1:0]  pown;
   logic [NUM_VIRT-1:0]  vout;
   logic                 lock;
   logic [DW-1:0]        out_img [NUM_OUT_REG];
   logic [DW-1:0]        in_img [NUM_IN_REG];
   logic                 lock_m = 1'b0;
   int                   fails = 0;
   int                   n_checks = 0;
   always #2 clk_i = ~clk_i;
   pin_remap_fabric dut (.clk_i(clk_i), .srst_i(srst_i), .wb_i(req),
      .wb_o(rsp), .pin_level_i(lvl), .periph_out_i(per), .func_in_o(fin),
      .pin_out_o(pout), .pin_own_o(pown), .virt_out_o(vout), .lock_o(lock));
   remap_far_side far (.clk_i(clk_i), .periph_o(per), .level_o(lvl));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Classic cycle held until ack is sampled at a rising edge; one idle
   // cycle follows so a second call never meets a strobe just released
   task automatic wb(input logic we, input logic [7:0] idx,
                     input logic [15:0] d, input logic [3:0] be,
                     output logic [15:0] q);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, we, {idx, 2'b00}, be, {16'h0000, d}};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (rsp.ack !== 1'b1 && n < 20);
      if (rsp.ack !== 1'b1)
      begin
         fails++;
         report_and_stop();
      end
      q = rsp.dat[15:0];
      req <= '0;
      @(posedge clk_i);
   endtask
   function automatic logic [15:0] in_mask(input int k);
      return {IN_HI_MASK[k] ? 8'hFF : 8'h00, IN_LO_MASK[k] ? 8'hFF : 8'h00};
   endfunction
   // Write and mirror into the bench image; lock blocks mapping words,
   // and only enabled byte lanes reach a register
   task automatic wr_lane(input logic [7:0] idx, input logic [15:0] d,
                          input logic [3:0] be);
      logic [15:0] q;
      logic [15:0] lm;
      lm = {{8{be[1]}}, {8{be[0]}}};
      wb(1'b1, idx, d, be, q);
      if (idx == IDX_LOCK)
         lock_m = be[1] ? d[LOCK_BIT] : lock_m;
      else if (!lock_m && idx >= IDX_OUT_BASE && idx < 8'h37)
         out_img[idx - IDX_OUT_BASE] = (out_img[idx - IDX_OUT_BASE] & ~lm)
                                       | (d & lm & OUT_MASK);
      else if (!lock_m && idx >= IDX_IN_BASE && idx <= IDX_IN_CNT)
         in_img[idx - IDX_IN_BASE] = (in_img[idx - IDX_IN_BASE] & ~lm)
            | (d & lm & in_mask(idx - IDX_IN_BASE));
   endtask
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      wr_lane(idx, d, 4'hF);
   endtask
   // Reads every word up to 0x37, unmapped ones expecting zero
   task automatic sweep;
      logic [15:0] q;
      logic [15:0] e;
      logic [NUM_CODES-1:0] pv;
      logic [NUM_CODES-1:0] pv0;
      logic [NUM_SRC-1:0] pl;
      logic [SEL_W-1:0] s;
      logic [SRC_W-1:0] b;
      for (int i = 0; i < 8'h38; i++)
      begin
         wb(1'b0, 8'(i), 16'h0000, 4'hF, q);
         e = 16'h0000;
         if (i == 0)
            e[LOCK_BIT] = lock_m;
         else if (i <= IDX_IN_CNT)
            e = in_img[i - 1];
         else if (i >= IDX_OUT_BASE && i < IDX_OUT_BASE + IDX_OUT_CNT)
            e = out_img[i - IDX_OUT_BASE];
         chk(q, e);
      end
      // Two settled samples: virtual outputs feed functions a cycle late
      @(negedge clk_i);
      pv0 = per;
      @(negedge clk_i);
      pv = per;
      pl = lvl;
      @(negedge clk_i);
      for (int p = 0; p < NUM_OUT_PIN; p++)
      begin
         s = out_img[p/2][(p%2)*8 +: SEL_W];
         if (p < NUM_PHYS)
         begin
            chk(pout[p], s != 0 ? pv[s] : 1'b0);
            chk(pown[p], s != 0);
         end
         else
            chk(vout[p - NUM_PHYS], s != 0 ? pv[s] : 1'b0);
      end
      for (int f = 0; f < NUM_FUNC; f++)
      begin
         b = in_img[f/2][(f%2)*8 +: SRC_W];
         e[0] = f % 2 ? IN_HI_MASK[f/2] : IN_LO_MASK[f/2];
         e[1] = pl[b];
         if (b >= VIRT_PIN_FIRST && b < VIRT_PIN_FIRST + NUM_VIRT)
         begin
            s = out_img[(NUM_PHYS + b - VIRT_PIN_FIRST) / 2]
                       [(b - VIRT_PIN_FIRST) % 2 * 8 +: SEL_W];
            e[1] = s != 0 ? pv0[s] : 1'b0;
         end
         chk(fin[f], e[0] ? e[1] : 1'b0);
      end
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hADC683D3));
      foreach (out_img[i])
         out_img[i] = '0;
      foreach (in_img[i])
         in_img[i] = '0;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      sweep();
      for (int i = 0; i < NUM_OUT_REG; i++)
         wr(IDX_OUT_BASE + 8'(i), 16'($urandom));
      wr(IDX_OUT_BASE, 16'h0101);
      for (int i = 0; i < NUM_IN_REG; i++)
         wr(IDX_IN_BASE + 8'(i), {8'($urandom_range(175, 0)),
                                  8'($urandom_range(175, 0))});
      // Virtual loop: pins 170 and 175 fed back into two functions
      wr(IDX_IN_BASE + 8'h01, 16'hAFAA);
      wr(IDX_OUT_BASE + 8'h14, 16'h0201);
      wr(IDX_OUT_BASE + 8'h16, 16'h3F05);
      sweep();
      wr(IDX_LOCK, 16'hFFFF);
      chk(lock, 1'b1);
      wr(IDX_OUT_BASE, 16'h0000);
      wr(IDX_IN_BASE + 8'h01, 16'h0000);
      sweep();
      wr(IDX_LOCK, 16'h0000);
      chk(lock, 1'b0);
      wr(IDX_OUT_BASE, 16'h0000);
      wr(8'h19, 16'hFFFF);
      // Single lanes: lower selector only, and the lock lane left out
      wr_lane(IDX_OUT_BASE + 8'h01, 16'h2A15, 4'h1);
      wr_lane(IDX_LOCK, 16'hFFFF, 4'h1);
      sweep();
      // Mid-run reset must clear every selector and the lock
      wr(IDX_LOCK, 16'h0800);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      lock_m = 1'b0;
      foreach (out_img[i])
         out_img[i] = '0;
      foreach (in_img[i])
         in_img[i] = '0;
      sweep();
      report_and_stop();
   end
endmodule
bind pin_remap_fabric pin_remap_fabric_props u_props (.clk_i(clk_i),
   .srst_i(srst_i), .wb_i(wb_i), .wb_o(wb_o), .pin_own_o(pin_own_o),
   .virt_out_o(virt_out_o), .lock_o(lock_o));
